// ---- fpr_consts.svh ----
/*
  Constants for the read-parameter / error register block: field positions,
  reset value, command codes, default dummy counts and link bit counts.
  Assumes it is included by the package and the top module of the block.
*/
`ifndef FPR_CONSTS_SVH
`define FPR_CONSTS_SVH

// register layout
`define FPR_REG_RESET 8'hE0
`define FPR_WRITABLE_RESET 4'hE
`define FPR_DRV_MSB 7
`define FPR_DRV_LSB 5
`define FPR_TRAIN_BIT 4
`define FPR_ERASE_FAIL_BIT 3
`define FPR_PROG_FAIL_BIT 2
`define FPR_PROT_BIT 1
`define FPR_RSVD_BIT 0

// reserved drive strength codes
`define FPR_DRV_RSVD_A 3'h0
`define FPR_DRV_RSVD_B 3'h4

// register commands
`define FPR_CMD_SET_NV 8'h85
`define FPR_CMD_SET_V 8'h83
`define FPR_CMD_READ 8'h81
`define FPR_CMD_CLEAR 8'h82

// fast read command family
`define FPR_CMD_FAST_A 8'h0B
`define FPR_CMD_FAST_B 8'h0C
`define FPR_CMD_FAST_DTR_A 8'h0D
`define FPR_CMD_FAST_DTR_B 8'h0E
`define FPR_CMD_UID 8'h4B
`define FPR_CMD_IROW 8'h68
`define FPR_CMD_DOUT_A 8'h3B
`define FPR_CMD_DOUT_B 8'h3C
`define FPR_CMD_QOUT_A 8'h6B
`define FPR_CMD_QOUT_B 8'h6C
`define FPR_CMD_DIO_A 8'hBB
`define FPR_CMD_DIO_B 8'hBC
`define FPR_CMD_DIO_DTR_A 8'hBD
`define FPR_CMD_DIO_DTR_B 8'hBE
`define FPR_CMD_QIO_A 8'hEB
`define FPR_CMD_QIO_B 8'hEC
`define FPR_CMD_QIO_DTR_A 8'hED
`define FPR_CMD_QIO_DTR_B 8'hEE

// default dummy cycle counts
`define FPR_DUMMY_FAST_SPI 4'h8
`define FPR_DUMMY_FAST_QPI 4'h6
`define FPR_DUMMY_OUT 4'h8
`define FPR_DUMMY_DIO 4'h4
`define FPR_DUMMY_QIO 4'h6

// link framing, in bits
`define FPR_CMD_BITS 5'h08
`define FPR_FRAME_BITS 5'h10
`define FPR_STEP_SINGLE 5'h01
`define FPR_STEP_QUAD 5'h04

`endif

// ---- fpr_pkg.sv ----
/*
  Types shared by the read-parameter / error register block.
  Assumes the constants header sits in the same folder.
*/
package fpr_pkg;
  `include "fpr_consts.svh"

  // kind of array or register operation that the engine reports on completion
  typedef enum logic [3:0] {
    FPR_OP_PROGRAM = 4'h0,
    FPR_OP_INFO_ROW_PROGRAM = 4'h1,
    FPR_OP_PROTECT_CONFIG = 4'h2,
    FPR_OP_PASSWORD_UNLOCK = 4'h3,
    FPR_OP_NV_REG_UPDATE = 4'h4,
    FPR_OP_WRITE_STATUS = 4'h5,
    FPR_OP_WRITE_FUNCTION = 4'h6,
    FPR_OP_ERASE = 4'h7,
    FPR_OP_CHIP_ERASE = 4'h8
  } fpr_op_t;

  typedef logic [7:0] fpr_byte_t;
endpackage

// ---- fpr_sync.sv ----
/*
  Two-flop level synchroniser, WIDTH bits wide.
  Assumes each bit is an independent level; multi-bit words must not pass here.
*/
`timescale 1ns/1ps
module fpr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      syncOut <= INIT;
    end else begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end
endmodule

// ---- fpr_toggle_rx.sv ----
/*
  Receiving end of a toggle event crossing: turns each change of a foreign
  toggle into one pulse on clk. Assumes toggles are spaced by more than
  three clk periods, which the slow link guarantees.
*/
`timescale 1ns/1ps
module fpr_toggle_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic toggleIn,
  output logic pulse
);
  logic synced;
  logic seen;

  fpr_sync #(.WIDTH(1), .INIT(1'b0)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(toggleIn),
    .syncOut(synced)
  );

  // edge detect on the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= 1'b0;
      pulse <= 1'b0;
    end else begin
      seen <= synced;
      pulse <= synced ^ seen;
    end
  end
endmodule

// ---- fpr_param_reg.sv ----
/*
  Read-parameter / error register of a serial flash, with the link-side
  command shifter that reaches it and the default dummy-cycle decoder.
  Assumes an array engine on ref_clk reports operation results, and a host
  that drives sck (mode 0) and csN and keeps its own link obligations.
*/
`timescale 1ns/1ps
`include "fpr_consts.svh"
module fpr_param_reg (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic csN,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic fourWireCommandMode,
  input wire logic wpN,
  input wire logic swReset,
  input wire logic opDone,
  input wire fpr_pkg::fpr_op_t opKind,
  input wire logic opFail,
  input wire logic opEraseFail,
  input wire logic targetProtected,
  input wire logic blockProtectHit,
  input wire logic modeAlreadySelected,
  input wire logic lockValueZero,
  input wire logic passwordMismatch,
  input wire logic statusWriteDisableBit,
  output logic [2:0] driveStrengthSel,
  output logic driveReserved,
  output logic trainingPatternEn,
  output logic eraseFailFlag,
  output logic programFailFlag,
  output logic protectViolationFlag,
  output logic [3:0] readDummy,
  output logic readCmdLegal,
  output logic nvWriteStart
);
  import fpr_pkg::*;

  // ---------------- dummy cycle decode ----------------
  // returns {legal, count}; a code that is no fast read is illegal with count 0
  function automatic logic [4:0] dummyOf(input fpr_byte_t cmd, input logic fourWire);
    logic [4:0] r;
    r = 5'h00;
    unique case (cmd)
      `FPR_CMD_FAST_A, `FPR_CMD_FAST_B, `FPR_CMD_FAST_DTR_A, `FPR_CMD_FAST_DTR_B,
      `FPR_CMD_UID, `FPR_CMD_IROW: begin
        r = {1'b1, fourWire ? `FPR_DUMMY_FAST_QPI : `FPR_DUMMY_FAST_SPI};
      end
      `FPR_CMD_DOUT_A, `FPR_CMD_DOUT_B, `FPR_CMD_QOUT_A, `FPR_CMD_QOUT_B: begin
        r = {~fourWire, `FPR_DUMMY_OUT};
      end
      `FPR_CMD_DIO_A, `FPR_CMD_DIO_B, `FPR_CMD_DIO_DTR_A, `FPR_CMD_DIO_DTR_B: begin
        r = {~fourWire, `FPR_DUMMY_DIO};
      end
      `FPR_CMD_QIO_A, `FPR_CMD_QIO_B, `FPR_CMD_QIO_DTR_A, `FPR_CMD_QIO_DTR_B: begin
        r = {1'b1, `FPR_DUMMY_QIO};
      end
      default: begin
        r = 5'h00;
      end
    endcase
    return r;
  endfunction

  // reserved codes are stored as written; the pad logic must treat them as default
  function automatic logic rsvdOf(input logic [2:0] code);
    return code == `FPR_DRV_RSVD_A || code == `FPR_DRV_RSVD_B;
  endfunction

  // ---------------- link domain (sck) ----------------
  logic fourWireLink;
  logic [4:0] bitCnt;
  fpr_byte_t shiftIn;
  fpr_byte_t rdWord;
  logic rdActive;
  logic [2:0] outPos;
  fpr_byte_t cmdWord;
  fpr_byte_t dataWord;
  logic cmdTog;
  logic dataTog;
  fpr_byte_t shadow;
  wire linkRst_n;
  wire [4:0] step;
  wire [4:0] next_bitCnt;
  wire [7:0] next_shiftIn;
  wire frameOpen;
  wire cmdDone;
  wire dataDone;
  wire [3:0] outNibble;
  wire outBit;

  // frame logic restarts whenever chip select is high, since sck may stop there
  assign linkRst_n = rst_n & ~csN;

  // bit assembly: one line in single-wire mode, a nibble in four-wire mode
  assign step = fourWireLink ? `FPR_STEP_QUAD : `FPR_STEP_SINGLE;
  assign next_bitCnt = bitCnt + step;
  assign next_shiftIn = fourWireLink ? {shiftIn[3:0], ioIn} : {shiftIn[6:0], ioIn[0]};
  assign frameOpen = bitCnt < `FPR_FRAME_BITS;
  assign cmdDone = frameOpen && (next_bitCnt == `FPR_CMD_BITS);
  assign dataDone = frameOpen && (next_bitCnt == `FPR_FRAME_BITS);

  // per-frame state, cleared by chip select
  always_ff @(posedge sck or negedge linkRst_n) begin
    if (!linkRst_n) begin
      bitCnt <= 5'h00;
      shiftIn <= 8'h00;
      rdActive <= 1'b0;
      rdWord <= 8'h00;
    end else begin
      if (frameOpen) begin
        bitCnt <= next_bitCnt;
        shiftIn <= next_shiftIn;
      end
      // shadow is frozen by the core while the frame is open, so it is stable here
      if (cmdDone && next_shiftIn == `FPR_CMD_READ) begin
        rdActive <= 1'b1;
        rdWord <= shadow;
      end
    end
  end

  // words and toggles survive chip select so no false event is made at frame end
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cmdWord <= 8'h00;
      dataWord <= 8'h00;
      cmdTog <= 1'b0;
      dataTog <= 1'b0;
    end else begin
      if (cmdDone) begin
        cmdWord <= next_shiftIn;
        cmdTog <= ~cmdTog;
      end
      if (dataDone) begin
        dataWord <= next_shiftIn;
        dataTog <= ~dataTog;
      end
    end
  end

  // read data out, msb first, changed on the falling edge; repeats until deselect
  assign outNibble = outPos[2] ? rdWord[3:0] : rdWord[7:4];
  assign outBit = rdWord[3'h7 - outPos];

  always_ff @(negedge sck or negedge linkRst_n) begin
    if (!linkRst_n) begin
      outPos <= 3'h0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
    end else if (rdActive) begin
      ioOe <= fourWireLink ? 4'hF : 4'h2;
      ioOut <= fourWireLink ? outNibble : {2'b00, outBit, 1'b0};
      outPos <= outPos + (fourWireLink ? 3'h4 : 3'h1);
    end
  end

  // ---------------- core domain (ref_clk) ----------------
  logic csIdle;
  logic wpNSync;
  logic cmdPulse;
  logic dataPulse;
  fpr_byte_t lastCmd;
  logic [3:0] volHi;
  logic [3:0] nvHi;
  logic reloadPend;
  wire [2:0] errSet;
  wire errClear;
  wire statusLocked;
  wire writeVol;
  wire writeNv;
  wire [4:0] dummyNow;
  wire fpr_byte_t regValue;
  logic setErase;
  logic setProg;
  logic setProt;

  // pins enter the core through two flops
  fpr_sync #(.WIDTH(2), .INIT(2'b11)) u_pin_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn({csN, wpN}),
    .syncOut({csIdle, wpNSync})
  );

  // command and data events cross by toggle; the words behind them are then stable
  fpr_toggle_rx u_cmd_rx (
    .clk(ref_clk),
    .rst_n(rst_n),
    .toggleIn(cmdTog),
    .pulse(cmdPulse)
  );

  fpr_toggle_rx u_data_rx (
    .clk(ref_clk),
    .rst_n(rst_n),
    .toggleIn(dataTog),
    .pulse(dataPulse)
  );

  // register image as software reads it; bit 0 always reads zero
  assign regValue = {volHi, eraseFailFlag, programFailFlag, protectViolationFlag, 1'b0};

  // shadow and link mode follow the core only between frames
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= `FPR_REG_RESET;
      fourWireLink <= 1'b0;
    end else if (csIdle) begin
      shadow <= regValue;
      fourWireLink <= fourWireCommandMode;
    end
  end

  // last command byte, and the dummy decode of it for the read engine
  assign dummyNow = dummyOf(cmdWord, fourWireCommandMode);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastCmd <= 8'h00;
      readDummy <= 4'h0;
      readCmdLegal <= 1'b0;
    end else if (cmdPulse) begin
      lastCmd <= cmdWord;
      readDummy <= dummyNow[3:0];
      readCmdLegal <= dummyNow[4];
    end
  end

  // set commands touch only bits 7..4; the flags have no write path at all
  assign writeVol = dataPulse && lastCmd == `FPR_CMD_SET_V;
  assign writeNv = dataPulse && lastCmd == `FPR_CMD_SET_NV;

  // non-volatile copy; survives software reset, reloads the volatile copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvHi <= `FPR_WRITABLE_RESET;
      nvWriteStart <= 1'b0;
    end else begin
      nvWriteStart <= writeNv;
      if (writeNv) begin
        nvHi <= dataWord[7:4];
      end
    end
  end

  // volatile copy drives the pads; a non-volatile write updates it too
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      volHi <= `FPR_WRITABLE_RESET;
      reloadPend <= 1'b1;
      driveReserved <= 1'b0;
    end else begin
      reloadPend <= swReset;
      if (writeVol || writeNv) begin
        volHi <= dataWord[7:4];
        driveReserved <= rsvdOf(dataWord[7:5]);
      end else if (reloadPend) begin
        volHi <= nvHi;
        driveReserved <= rsvdOf(nvHi[3:1]);
      end
    end
  end

  // drive strength and training enable come straight from the volatile copy
  assign driveStrengthSel = volHi[3:1];
  assign trainingPatternEn = volHi[0];

  // status register lock needs both the disable bit and the pin held low
  assign statusLocked = statusWriteDisableBit & ~wpNSync;

  // map an operation result onto the three error flags
  always_comb begin
    setErase = 1'b0;
    setProg = 1'b0;
    setProt = 1'b0;
    unique case (opKind)
      FPR_OP_PROGRAM: begin
        setProg = opFail | targetProtected;
        setProt = targetProtected;
      end
      FPR_OP_INFO_ROW_PROGRAM: begin
        setProg = opFail | targetProtected;
        setProt = targetProtected;
      end
      FPR_OP_PROTECT_CONFIG: begin
        setProg = opFail | modeAlreadySelected | lockValueZero;
        setProt = modeAlreadySelected | lockValueZero;
      end
      FPR_OP_PASSWORD_UNLOCK: begin
        setProg = passwordMismatch;
        setProt = passwordMismatch;
      end
      FPR_OP_NV_REG_UPDATE: begin
        setErase = opEraseFail;
        setProg = opFail;
      end
      FPR_OP_WRITE_STATUS: begin
        setErase = opEraseFail | statusLocked;
        setProg = opFail;
        setProt = statusLocked;
      end
      FPR_OP_WRITE_FUNCTION: begin
        setProg = opFail;
      end
      FPR_OP_ERASE: begin
        setErase = opFail | targetProtected;
        setProt = targetProtected;
      end
      FPR_OP_CHIP_ERASE: begin
        // sector-level protection alone is skipped silently, only block bits count
        setErase = opFail | blockProtectHit;
        setProt = blockProtectHit;
      end
      default: begin
        setErase = 1'b0;
        setProg = 1'b0;
        setProt = 1'b0;
      end
    endcase
  end

  assign errSet = opDone ? {setErase, setProg, setProt} : 3'b000;
  assign errClear = (cmdPulse && cmdWord == `FPR_CMD_CLEAR) || swReset;

  // sticky flags: a set in the clearing cycle wins, so no failure is lost;
  // nothing here stalls the command path, later commands still run
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eraseFailFlag <= 1'b0;
      programFailFlag <= 1'b0;
      protectViolationFlag <= 1'b0;
    end else begin
      eraseFailFlag <= (eraseFailFlag & ~errClear) | errSet[2];
      programFailFlag <= (programFailFlag & ~errClear) | errSet[1];
      protectViolationFlag <= (protectViolationFlag & ~errClear) | errSet[0];
    end
  end
endmodule

// ---- fpr_param_reg_sva.sv ----
/*
  Checker for the read-parameter / error register: flag causes, stickiness, decodes.
  Assumes it is bound to fpr_param_reg and sees only that module's ports.
*/
`timescale 1ns/1ps
module fpr_param_reg_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic wpN,
  input wire logic swReset,
  input wire logic opDone,
  input wire fpr_pkg::fpr_op_t opKind,
  input wire logic opFail,
  input wire logic opEraseFail,
  input wire logic targetProtected,
  input wire logic blockProtectHit,
  input wire logic passwordMismatch,
  input wire logic statusWriteDisableBit,
  input wire logic [2:0] driveStrengthSel,
  input wire logic driveReserved,
  input wire logic eraseFailFlag,
  input wire logic programFailFlag,
  input wire logic protectViolationFlag,
  input wire logic [3:0] readDummy,
  input wire logic readCmdLegal
);
  import fpr_pkg::*;
  logic [3:0] csIdle;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // cycles since the link was last selected; a clear command can only come from a frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) csIdle <= 4'h0;
    else if (!csN) csIdle <= 4'h0;
    else if (csIdle != 4'hF) csIdle <= csIdle + 4'h1;
  end
  chk_erase_protect: assert property (opDone && opKind == FPR_OP_ERASE && targetProtected |=> eraseFailFlag && protectViolationFlag)
    else $error("protected erase left a flag clear");
  chk_prog_fail: assert property (opDone && opKind == FPR_OP_PROGRAM && opFail |=> programFailFlag)
    else $error("failed program left program flag clear");
  chk_pwd_mismatch: assert property (opDone && opKind == FPR_OP_PASSWORD_UNLOCK && passwordMismatch |=> programFailFlag && protectViolationFlag)
    else $error("password mismatch not flagged");
  chk_nv_erase: assert property (opDone && opKind == FPR_OP_NV_REG_UPDATE && opEraseFail |=> eraseFailFlag)
    else $error("nv update erase failure not flagged");
  chk_status_lock: assert property (opDone && opKind == FPR_OP_WRITE_STATUS && statusWriteDisableBit
    && !(wpN || $past(wpN) || $past(wpN, 2) || $past(wpN, 3)) |=> eraseFailFlag && protectViolationFlag)
    else $error("locked status write not flagged");
  chk_chip_erase: assert property (opDone && opKind == FPR_OP_CHIP_ERASE && !blockProtectHit && !protectViolationFlag |=> !protectViolationFlag)
    else $error("chip erase flagged without block protection");
  chk_flags_sticky: assert property ($fell(eraseFailFlag) || $fell(programFailFlag) || $fell(protectViolationFlag)
    |-> $past(swReset) || csIdle < 4'hC)
    else $error("error flag dropped without clear or reset");
  chk_rsvd_decode: assert property (driveReserved == (driveStrengthSel == 3'h0 || driveStrengthSel == 3'h4))
    else $error("reserved drive code decode wrong");
  chk_dummy_count: assert property (readCmdLegal |-> readDummy == 4'h4 || readDummy == 4'h6 || readDummy == 4'h8)
    else $error("legal read with odd dummy count");
endmodule
bind fpr_param_reg fpr_param_reg_sva u_fpr_param_reg_sva (.ref_clk(ref_clk), .rst_n(rst_n), .csN(csN), .wpN(wpN),
  .swReset(swReset), .opDone(opDone), .opKind(opKind), .opFail(opFail), .opEraseFail(opEraseFail),
  .targetProtected(targetProtected), .blockProtectHit(blockProtectHit), .passwordMismatch(passwordMismatch),
  .statusWriteDisableBit(statusWriteDisableBit), .driveStrengthSel(driveStrengthSel), .driveReserved(driveReserved),
  .eraseFailFlag(eraseFailFlag), .programFailFlag(programFailFlag), .protectViolationFlag(protectViolationFlag),
  .readDummy(readDummy), .readCmdLegal(readCmdLegal));

// ---- fpr_host_model.sv ----
/*
  Host side of the serial link: drives sck, csN and the io lines frame by frame.
  Assumes the device samples on rising sck and drives read data on falling sck.
*/
`timescale 1ns/1ps
module fpr_host_model (
  output logic sck,
  output logic csN,
  output wire logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  logic [3:0] hostOut;
  // each wire shows the device where it drives, the host elsewhere, so no line is contended
  assign ioIn = (ioOe & ioOut) | (~ioOe & hostOut);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    hostOut = 4'h5;
  end
  // one frame, msb first; sck stands still outside frames and idle lines toggle
  task automatic xfer(input logic [15:0] bits, input int nbits, input logic quad, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    #37 csN = 1'b0;
    for (i = 0; i < nbits; i += (quad ? 4 : 1)) begin
      hostOut = quad ? bits[15 - i -: 4] : {~hostOut[3:1], bits[15 - i]};
      #80 sck = 1'b1;
      rd = {rd[6:0], ioIn[1]};
      #80 sck = 1'b0;
    end
    #40 csN = 1'b1;
    hostOut = ~hostOut;
  endtask
endmodule

// ---- fpr_param_reg_tb.sv ----
/*
  Self-checking bench for the read-parameter / error register.
  Assumes the package, design, host model and checker are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t %s", $time, m); end end
module fpr_param_reg_tb;
  import fpr_pkg::*;
  logic ref_clk, rst_n, fourWireCommandMode, wpN, swReset, opDone, opFail, opEraseFail, targetProtected;
  logic blockProtectHit, modeAlreadySelected, lockValueZero, passwordMismatch, statusWriteDisableBit;
  logic driveReserved, trainingPatternEn, eraseFailFlag, programFailFlag, protectViolationFlag;
  logic readCmdLegal, nvWriteStart, sck, csN;
  logic [3:0] ioIn, ioOut, ioOe, readDummy, kk;
  logic [2:0] driveStrengthSel;
  logic [7:0] rd, d, c;
  logic [8:0] r;
  logic [4:0] e;
  fpr_op_t opKind;
  int n_errors, checked, nvCount, i, j;
  logic [7:0] cmdList [18] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h4B, 8'h68, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
    8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hEB, 8'hEC, 8'hED, 8'hEE};
  fpr_param_reg u_fpr_param_reg (.ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .csN(csN), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .fourWireCommandMode(fourWireCommandMode), .wpN(wpN), .swReset(swReset),
    .opDone(opDone), .opKind(opKind), .opFail(opFail), .opEraseFail(opEraseFail), .targetProtected(targetProtected),
    .blockProtectHit(blockProtectHit), .modeAlreadySelected(modeAlreadySelected), .lockValueZero(lockValueZero),
    .passwordMismatch(passwordMismatch), .statusWriteDisableBit(statusWriteDisableBit),
    .driveStrengthSel(driveStrengthSel), .driveReserved(driveReserved), .trainingPatternEn(trainingPatternEn),
    .eraseFailFlag(eraseFailFlag), .programFailFlag(programFailFlag), .protectViolationFlag(protectViolationFlag),
    .readDummy(readDummy), .readCmdLegal(readCmdLegal), .nvWriteStart(nvWriteStart));
  fpr_host_model u_fpr_host_model (.sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  // core clock, 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // count nv update requests seen by the engine
  always @(posedge ref_clk) if (nvWriteStart === 1'b1) nvCount++;
  // expected {legal, dummy} of a command byte in a command mode
  function automatic logic [4:0] expRead(input logic [7:0] cb, input logic q);
    case (cb)
      8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h4B, 8'h68: return {1'b1, q ? 4'h6 : 4'h8};
      8'h3B, 8'h3C, 8'h6B, 8'h6C: return {~q, 4'h8};
      8'hBB, 8'hBC, 8'hBD, 8'hBE: return {~q, 4'h4};
      8'hEB, 8'hEC, 8'hED, 8'hEE: return {1'b1, 4'h6};
      default: return 5'h00;
    endcase
  endfunction
  // expected {erase, program, protect} flags after one report from a clear state
  function automatic logic [2:0] expFlags(input fpr_op_t k);
    case (k)
      FPR_OP_PROGRAM, FPR_OP_INFO_ROW_PROGRAM: return {1'b0, opFail | targetProtected, targetProtected};
      FPR_OP_PROTECT_CONFIG: return {1'b0, opFail | modeAlreadySelected | lockValueZero, modeAlreadySelected | lockValueZero};
      FPR_OP_PASSWORD_UNLOCK: return {1'b0, passwordMismatch, passwordMismatch};
      FPR_OP_NV_REG_UPDATE: return {opEraseFail, opFail, 1'b0};
      FPR_OP_WRITE_STATUS: return {opEraseFail | (statusWriteDisableBit & ~wpN), opFail, statusWriteDisableBit & ~wpN};
      FPR_OP_WRITE_FUNCTION: return {1'b0, opFail, 1'b0};
      FPR_OP_ERASE: return {opFail | targetProtected, 1'b0, targetProtected};
      default: return {opFail | blockProtectHit, 1'b0, blockProtectHit};
    endcase
  endfunction
  // one link frame, then let the crossing settle; mode only changes with csN high
  task automatic frame(input logic [15:0] b, input int n, input logic q);
    @(posedge ref_clk) fourWireCommandMode <= q;
    u_fpr_host_model.xfer(b, n, q, rd);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // set engine qualifiers; wpN for every kind, targetProtected also for chip erase, each other only where its kind gives it meaning
  task automatic setOp(input logic [3:0] k, input logic [8:0] q);
    @(posedge ref_clk) opKind <= fpr_op_t'(k);
    opFail <= q[0] & (k != 4'h3);
    targetProtected <= q[1] & (k < 4'h2 || k > 4'h6);
    modeAlreadySelected <= q[2] & (k == 4'h2);
    lockValueZero <= q[3] & (k == 4'h2);
    passwordMismatch <= q[4] & (k == 4'h3);
    statusWriteDisableBit <= q[5] & (k == 4'h5);
    blockProtectHit <= q[6] & (k == 4'h8);
    opEraseFail <= q[7] & (k == 4'h4 || k == 4'h5);
    wpN <= q[8];
  endtask
  // one report pulse from the engine
  task automatic pulse();
    @(posedge ref_clk) opDone <= 1'b1;
    @(posedge ref_clk) opDone <= 1'b0;
    @(negedge ref_clk);
  endtask
  // reset, then reset values at the pins and through a register read
  task automatic resetDut();
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK({driveStrengthSel, trainingPatternEn, eraseFailFlag, programFailFlag, protectViolationFlag, driveReserved}, 8'hE0, "reset pins")
    frame(16'h8100, 16, 1'b0);
    `CHK(rd, 8'hE0, "reset readback")
    $display("test reset done, errors %0d", n_errors);
  endtask
  task automatic complete_run();
    $display("checked %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the whole run needs well under a millisecond
  initial begin
    #1000000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    {rst_n, fourWireCommandMode, swReset, opDone, opFail, opEraseFail, targetProtected} = 7'h00;
    {blockProtectHit, modeAlreadySelected, lockValueZero, passwordMismatch, statusWriteDisableBit} = 5'h00;
    wpN = 1'b1;
    opKind = FPR_OP_PROGRAM;
    n_errors = 0;
    checked = 0;
    nvCount = 0;
    void'($urandom(19731));
    resetDut();
    // default dummy table in both command modes, with random command bytes among it
    for (i = 0; i < 56; i++) begin
      c = (i % 28 < 18) ? cmdList[i % 28] : 8'($urandom);
      frame({c, 8'h00}, 8, i >= 28);
      e = expRead(c, i >= 28);
      `CHK(readCmdLegal, e[4], "read legality")
      if (e[4]) `CHK(readDummy, e[3:0], "dummy count")
    end
    $display("test dummy done, errors %0d", n_errors);
    // every drive code written with flags set, alternating command modes
    setOp(4'h7, 9'h102);
    pulse();
    for (j = 0; j < 8; j++) begin
      d = {3'(j), 5'($urandom)};
      frame({8'h83, d}, 16, j[0]);
      `CHK({driveStrengthSel, trainingPatternEn, driveReserved}, {d[7:4], j == 0 || j == 4}, "volatile write")
      frame(16'h8100, 16, 1'b0);
      `CHK(rd, {d[7:4], 4'hA}, "readback keeps flags")
    end
    $display("test write done, errors %0d", n_errors);
    // nv copy survives a software reset, volatile copy does not
    j = nvCount;
    d = {3'h3, 5'($urandom)};
    frame({8'h85, d}, 16, 1'b0);
    `CHK(nvCount, j + 1, "nv update request")
    frame(16'h83C0, 16, 1'b0);
    @(posedge ref_clk) swReset <= 1'b1;
    @(posedge ref_clk) swReset <= 1'b0;
    @(negedge ref_clk);
    `CHK({eraseFailFlag, programFailFlag, protectViolationFlag}, 3'h0, "flags after soft reset")
    @(negedge ref_clk);
    `CHK({driveStrengthSel, trainingPatternEn}, d[7:4], "nv copy reload")
    $display("test soft reset done, errors %0d", n_errors);
    // random engine reports, each after a link clear
    for (i = 0; i < 40; i++) begin
      kk = 4'($urandom_range(8));
      r = 9'($urandom);
      setOp(kk, r);
      frame(16'h8200, 8, 1'b0);
      `CHK({eraseFailFlag, programFailFlag, protectViolationFlag}, 3'h0, "link clear")
      pulse();
      `CHK({eraseFailFlag, programFailFlag, protectViolationFlag}, expFlags(opKind), "flags after report")
    end
    $display("test reports done, errors %0d", n_errors);
    resetDut();
    complete_run();
  end
endmodule
